// ---- logic/baud_rate_gen.sv ----
// Function
// - Bit rate is source over 64, prescale, rate
// - Prescale codes give 1, 3, 4, 13
// - Rate codes give two to the code
// - Source select high picks bus clock
// - All 32 code combinations are usable
// - One rate shared by receiver and transmitter
// - Reset clears both select fields
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module baud_rate_gen
  import baud_gen_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic baud_source_select,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  output logic sample_tick,
  output logic bit_tick
);

  // ----------------------------------------
  // Source select synchroniser
  // ----------------------------------------
  logic source_meta; // First stage only
  logic source_sync; // Safe copy

  // The select comes from configuration logic that may not share our clock
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      source_meta <= 1'b0;
      source_sync <= 1'b0;
    end else begin
      source_meta <= baud_source_select;
      source_sync <= source_meta;
    end
  end

  // ----------------------------------------
  // Divisor fields
  // ----------------------------------------
  logic [1:0] prescale_select; // prescale_select_high/low
  logic [2:0] rate_select; // rate_select_bit2..0
  logic field_write; // Any write of the divisor register
  logic source_last; // For detecting a source change

  assign field_write = reg_write && (reg_addr == ADDR_RATE_CTRL);

  // Software writes the fields; reset clears them to divisors 1 and 1
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      prescale_select <= PRESCALE_SEL_RESET;
      rate_select <= RATE_SEL_RESET;
    end else if (field_write) begin
      prescale_select <= reg_wdata[PRESCALE_SEL_MSB:PRESCALE_SEL_LSB];
      rate_select <= reg_wdata[RATE_SEL_MSB:RATE_SEL_LSB];
    end
  end

  // Remember the source to restart the chain when it changes
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      source_last <= 1'b0;
    end else begin
      source_last <= source_sync;
    end
  end

  // ----------------------------------------
  // Divider chain
  // ----------------------------------------
  logic restart; // Clean restart of every stage
  logic source_tick; // Selected source clock as an enable
  logic prescale_tick; // After prescaler
  logic rate_tick; // After rate divisor = sample rate
  logic [5:0] oversample; // Sample ticks within one bit

  assign restart = field_write || (source_sync != source_last);
  // With select high the bus clock (our clock) feeds the chain; the other
  // source is not implemented, so select low holds the chain stopped.
  assign source_tick = source_sync;

  // Prescaler stage
  baud_div_counter #(.WIDTH(4)) u_prescale (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .restart(restart),
    .tick_in(source_tick),
    .divisor(prescale_divisor(prescale_select)),
    .tick_out(prescale_tick)
  );

  // Rate divisor stage
  baud_div_counter #(.WIDTH(8)) u_rate (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .restart(restart),
    .tick_in(prescale_tick),
    .divisor(rate_divisor(rate_select)),
    .tick_out(rate_tick)
  );

  // Sample pulse and divide-by-64 bit pulse, shared by both directions
  always_ff @(posedge clk_sys) begin
    if (!reset_n || restart) begin
      oversample <= '0;
      sample_tick <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      sample_tick <= rate_tick;
      if (rate_tick) begin
        oversample <= oversample + 6'h01;
        bit_tick <= (oversample == OVERSAMPLE_LAST);
      end else begin
        bit_tick <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !reg_read) begin
      reg_rdata <= 8'h00;
    end else begin
      unique case (reg_addr)
        ADDR_RATE_CTRL: reg_rdata <= {2'h0, prescale_select, 1'b0, rate_select};
        ADDR_RATE_STATUS: reg_rdata <= {1'b0, source_sync, oversample};
        default: reg_rdata <= 8'h00; // Unmapped reads zero
      endcase
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_reset_fields;
    @(posedge clk_sys) !reset_n |=> (prescale_select == 2'h0 && rate_select == 3'h0);
  endproperty
  a_reset_fields: assert property (p_reset_fields) else $error("fields not cleared");

  property p_write_restarts;
    @(posedge clk_sys) disable iff (!reset_n)
      field_write |=> (oversample == 6'h00 && !bit_tick && !sample_tick);
  endproperty
  a_write_restarts: assert property (p_write_restarts) else $error("no restart");

  property p_fastest_spacing;
    @(posedge clk_sys) disable iff (!reset_n)
      (source_sync && prescale_select == 2'h0 && rate_select == 3'h0 && !restart
       && sample_tick) ##1 !restart |-> sample_tick;
  endproperty
  a_fastest_spacing: assert property (p_fastest_spacing) else $error("rate 1 gap");

  property p_prescale_three;
    @(posedge clk_sys) disable iff (!reset_n)
      (prescale_tick && prescale_select == 2'h1 && rate_select == 3'h0 && !restart)
      ##1 !restart [*3] |-> prescale_tick;
  endproperty
  a_prescale_three: assert property (p_prescale_three) else $error("prescale 3 wrong");

  property p_rate_two;
    @(posedge clk_sys) disable iff (!reset_n)
      (rate_tick && source_sync && prescale_select == 2'h0 && rate_select == 3'h1
       && !restart) ##1 !restart |-> !rate_tick;
  endproperty
  a_rate_two: assert property (p_rate_two) else $error("rate 2 wrong");

  property p_source_low_stops;
    @(posedge clk_sys) disable iff (!reset_n)
      (!source_sync && !source_last) [*3] |-> !prescale_tick;
  endproperty
  a_source_low_stops: assert property (p_source_low_stops) else $error("ran unselected");

  property p_bit_after_sample;
    @(posedge clk_sys) disable iff (!reset_n) bit_tick |-> $past(rate_tick) && sample_tick;
  endproperty
  a_bit_after_sample: assert property (p_bit_after_sample) else $error("bit w/o sample");

  property p_read_one_cycle;
    @(posedge clk_sys) disable iff (!reset_n) !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  a_read_one_cycle: assert property (p_read_one_cycle) else $error("rdata held");

endmodule : baud_rate_gen

`default_nettype wire

// ---- include/baud_gen_pkg.sv ----
package baud_gen_pkg;

  // ----------------------------------------
  // Register map of the plain register port
  // ----------------------------------------
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] ADDR_RATE_CTRL = 4'h0;   // Divisor fields
  localparam logic [3:0] ADDR_RATE_STATUS = 4'h1; // Live divider state

  // Field positions in the rate control register
  localparam int unsigned RATE_SEL_LSB = 0;
  localparam int unsigned RATE_SEL_MSB = 2;
  localparam int unsigned PRESCALE_SEL_LSB = 4;
  localparam int unsigned PRESCALE_SEL_MSB = 5;

  // Reset values of the fields
  localparam logic [1:0] PRESCALE_SEL_RESET = 2'h0;
  localparam logic [2:0] RATE_SEL_RESET = 3'h0;

  // ----------------------------------------
  // Divider constants
  // ----------------------------------------
  localparam logic [5:0] OVERSAMPLE_LAST = 6'h3f; // 64 sample ticks per bit
  localparam logic [3:0] PRESCALE_DIV_0 = 4'h1;
  localparam logic [3:0] PRESCALE_DIV_1 = 4'h3;
  localparam logic [3:0] PRESCALE_DIV_2 = 4'h4;
  localparam logic [3:0] PRESCALE_DIV_3 = 4'hd;

  // Prescaler divisor from its 2-bit code
  function automatic logic [3:0] prescale_divisor(input logic [1:0] code);
    unique case (code)
      2'h0: prescale_divisor = PRESCALE_DIV_0;
      2'h1: prescale_divisor = PRESCALE_DIV_1;
      2'h2: prescale_divisor = PRESCALE_DIV_2;
      2'h3: prescale_divisor = PRESCALE_DIV_3;
    endcase
  endfunction : prescale_divisor

  // Rate divisor is two to the power of the code
  function automatic logic [7:0] rate_divisor(input logic [2:0] code);
    rate_divisor = 8'h01 << code;
  endfunction : rate_divisor

endpackage : baud_gen_pkg

// ---- logic/baud_div_counter.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Programmable modulo counter
// ----------------------------------------
// Pulses tick_out once every 'divisor' enabled cycles. A restart reloads it.
module baud_div_counter
  import baud_gen_pkg::*;
#(
  parameter int unsigned WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic restart,
  input wire logic tick_in,
  input wire logic [WIDTH-1:0] divisor,
  output logic tick_out
);

  logic [WIDTH-1:0] count; // Counts enabled cycles in this period

  // Count up, wrap at divisor-1 and emit one pulse there
  always_ff @(posedge clk_sys) begin
    if (!reset_n || restart) begin
      count <= '0;
      tick_out <= 1'b0;
    end else if (tick_in) begin
      if (count >= divisor - WIDTH'(1)) begin
        count <= '0;
        tick_out <= 1'b1;
      end else begin
        count <= count + WIDTH'(1);
        tick_out <= 1'b0;
      end
    end else begin
      tick_out <= 1'b0;
    end
  end

endmodule : baud_div_counter

`default_nettype wire

// ---- bench/shift_logic_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Shift logic stand-in: gauges tick spacing
// ----------------------------------------
module shift_logic_model (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sample_tick,
  input wire logic bit_tick,
  output logic [19:0] sample_gap,
  output logic [19:0] bit_gap,
  output logic [7:0] samples_in_bit
);
  logic [19:0] s_cnt; // Cycles since last sample tick
  logic [19:0] b_cnt; // Cycles since last bit tick
  logic [7:0] n_smp; // Sample ticks in current bit

  // Receiver and transmitter both clock off these same ticks
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s_cnt <= 20'h1;
      b_cnt <= 20'h1;
      n_smp <= 8'h0;
      sample_gap <= 20'h0;
      bit_gap <= 20'h0;
      samples_in_bit <= 8'h0;
    end else begin
      s_cnt <= sample_tick ? 20'h1 : s_cnt + 20'h1;
      b_cnt <= bit_tick ? 20'h1 : b_cnt + 20'h1;
      n_smp <= bit_tick ? 8'h0 : n_smp + {7'h0, sample_tick};
      if (sample_tick) begin
        sample_gap <= s_cnt;
      end
      // Bit tick lands on the 64th sample, so count it in
      if (bit_tick) begin
        bit_gap <= b_cnt;
        samples_in_bit <= n_smp + 8'h1;
      end
    end
  end
endmodule : shift_logic_model

`default_nettype wire

// ---- bench/test_serial_baud_rate_generator.sv ----
`timescale 1ns/1ps
`default_nettype none

module test_serial_baud_rate_generator;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clk_sys, reset_n, src_sel, reg_write, reg_read;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic sample_tick, bit_tick;
  logic [19:0] sample_gap, bit_gap;
  logic [7:0] samples_in_bit;
  int n_fail = 0;
  int check_count = 0;
  int cyc = 0;
  logic [31:0] prescale_tab [4] = '{32'h1, 32'h3, 32'h4, 32'hd}; // Prescale divisors

  baud_rate_gen u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .baud_source_select(src_sel),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .sample_tick(sample_tick), .bit_tick(bit_tick));
  shift_logic_model u_far (.clk_sys(clk_sys), .reset_n(reset_n), .sample_tick(sample_tick),
    .bit_tick(bit_tick), .sample_gap(sample_gap), .bit_gap(bit_gap),
    .samples_in_bit(samples_in_bit));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  // Hang guard; the whole run needs about 60k cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 90000) begin
      n_fail++;
      give_verdict();
    end
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  task automatic count_bits(input int n, input int lim, output int k);
    int t;
    k = 0;
    t = 0;
    while (k < n && t < lim) begin
      @(negedge clk_sys);
      t++;
      if (bit_tick === 1'b1) k++;
      if (sample_tick === 1'b1 && !src_sel) k++;
    end
  endtask : count_bits

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic measure(input logic [1:0] pc, input logic [2:0] rc);
    logic [31:0] per;
    logic [7:0] d;
    int k;
    per = prescale_tab[pc] << rc;
    wr(4'h0, {2'h0, pc, 1'b0, rc});
    rd(4'h0, d);
    check("rate_ctrl", {24'h0, d}, {26'h0, pc, 1'b0, rc});
    count_bits(3, 40000, k);
    check("bit_ticks", k, 32'h3);
    check("sample_gap", {12'h0, sample_gap}, per);
    check("bit_gap", {12'h0, bit_gap}, per * 64);
    check("samples_in_bit", {24'h0, samples_in_bit}, 32'h40);
  endtask : measure

  task automatic regs_after_reset();
    logic [7:0] d;
    rd(4'h0, d);
    check("fields_at_reset", {24'h0, d}, 32'h0);
    wr(4'h7, 8'hff);
    rd(4'h7, d);
    check("unmapped", {24'h0, d}, 32'h0);
    rd(4'h1, d);
    check("source_sync", {31'h0, d[6]}, 32'h1);
  endtask : regs_after_reset

  // Source off means no ticks at all
  task automatic source_off();
    int k;
    // Inputs move only right after a rising edge
    @(posedge clk_sys);
    src_sel <= 1'b0;
    repeat (4) @(posedge clk_sys);
    count_bits(1, 300, k);
    check("ticks_source_off", k, 32'h0);
    @(posedge clk_sys);
    src_sel <= 1'b1;
  endtask : source_off

  task automatic reset_mid_run();
    logic [7:0] d;
    // Fast rate, so a reset that failed to stop the chain shows ticks at once
    wr(4'h0, 8'h01);
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b0;
    // Look between edges, where the registered ticks have settled
    repeat (2) begin
      @(posedge clk_sys);
      @(negedge clk_sys);
      check("tick_in_reset", {31'h0, sample_tick}, 32'h0);
    end
    @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(4'h0, d);
    check("fields_after_reset", {24'h0, d}, 32'h0);
  endtask : reset_mid_run

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset_n = 1'b0;
    src_sel = 1'b0;
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    src_sel <= 1'b1;
    repeat (4) @(posedge clk_sys);
    regs_after_reset();
    for (int p = 0; p < 4; p++) measure(p[1:0], 3'h0);
    for (int r = 0; r < 8; r++) measure(2'h0, r[2:0]);
    measure(2'h3, 3'h1);
    source_off();
    measure(2'h1, 3'h2);
    reset_mid_run();
    give_verdict();
  end
endmodule : test_serial_baud_rate_generator

`default_nettype wire
